//--- aas_pkg.sv
// Contract
// - Stopped system clock freezes converter and control state.
// - Aux DAC writes work without system clock.
// - Reset: gain DACs zero, frequency DAC mid.
// - Shutdown zeroes DACs; other modes hold codes.
// - Start self-clears; start writes ignored while busy.
// - Reference select: zero bandgap, one supply.
// - Input select routes one of four sources.
// - Averaging code sets conversions per start.
// - Divider code divides clock by power-of-two.
// - Each conversion takes twelve conversion-clock edges.
// - Output floats, then busy high, ready low.
// - Enabled result shifts MSB first, falling edges.
// - Sixteen-clock read; last bit held six clocks.
// - Chip-select high returns serial data output to busy/ready level.
// - Output enable clear: result never shifted.
// - Unread result blocks starts; repeat disables output.
// - Back-to-back: read old, load next command.
// - Sixteen-bit write; DAC and power writes act on sixteenth clock, control at chip-select rise.
package aas_pkg;
  localparam int WORD_W   = 16;    // Serial frame length
  localparam int ADDR_W   = 4;     // Address field of a frame
  localparam int DATA_W   = 12;    // Data field of a frame
  localparam int RES_W    = 10;    // Converter result width
  localparam int DAC_W    = 12;    // Aux DAC code width
  localparam int CTRL_W   = 11;    // Converter control width
  localparam int ACC_W    = 15;    // Holds 32 results of 10 bits
  localparam int DIVC_W   = 7;     // Divider counter width
  localparam int CONV_EDGES = 12;  // Conversion-clock edges per conversion
  localparam int SAMPLE_EDGE = 0;  // Edge on which the input is sampled
  localparam logic [2:0] AVG_SHIFT_MAX = 3'h5;  // 32 averages at most
  localparam logic [ADDR_W-1:0] ADDR_DAC_FREQ = 4'h1;  // Frequency DAC
  localparam logic [ADDR_W-1:0] ADDR_DAC_GA   = 4'h2;  // Gain DAC A
  localparam logic [ADDR_W-1:0] ADDR_DAC_GB   = 4'h3;  // Gain DAC B
  localparam logic [ADDR_W-1:0] ADDR_AUX_CTRL = 4'h4;  // Converter control
  localparam logic [ADDR_W-1:0] ADDR_POWER    = 4'h5;  // Power mode
  localparam logic [DAC_W-1:0]  DAC_FREQ_RESET = 12'h800;  // Mid-level
  localparam logic [DAC_W-1:0]  DAC_GAIN_RESET = 12'h000;  // Zero output
  localparam logic [DAC_W-1:0]  DAC_OFF        = 12'h000;  // Shutdown level
  localparam logic [CTRL_W-1:0] CTRL_RESET     = 11'h000;  // All defaults
  localparam logic [3:0] RES_LAST_IDX = 4'h9;  // Index of last result bit

  // Converter control, bit 10 down to bit 0
  typedef struct packed {
    logic       aux_result_output_enable;
    logic [2:0] aux_clock_divider;
    logic [2:0] aux_average_count;
    logic [1:0] aux_input_select;
    logic       aux_reference_select;
    logic       aux_start_convert;
  } aas_ctrl_s;

  // One serial frame
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } aas_word_s;

  typedef enum logic [1:0] {PM_NORMAL, PM_IDLE, PM_STANDBY, PM_SHUTDOWN} aas_pmode_e;
  typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_READY} aas_state_e;

  // Averaging code to log2 of the number of conversions
  function automatic logic [2:0] aas_avg_shift(input logic [2:0] code);
    return (code > AVG_SHIFT_MAX) ? AVG_SHIFT_MAX : code;
  endfunction : aas_avg_shift
endpackage : aas_pkg

//--- aas_conv_seq.sv
`timescale 1ns/100ps
// Conversion sequencer: divider, twelve-edge cycles, averaging
module aas_conv_seq (
  input  wire logic                     clock,      // System clock
  input  wire logic                     rst_n,      // Synchronous reset
  input  wire logic                     start,      // Begin a conversion set
  input  wire logic [2:0]               avg_code,   // Averaging code
  input  wire logic [2:0]               div_code,   // Divider code
  input  wire logic [aas_pkg::RES_W-1:0] code_in,   // Synchronised converter code
  output logic                          busy,       // Set in progress
  output logic                          done,       // One-cycle completion pulse
  output logic [aas_pkg::RES_W-1:0]     result      // Averaged result
);
  import aas_pkg::*;

  logic                busy_reg,    busy_next;     // Running flag
  logic                done_reg,    done_next;     // Completion pulse
  logic [DIVC_W-1:0]   div_cnt_reg, div_cnt_next;  // Divider phase
  logic [DIVC_W-1:0]   div_max_reg, div_max_next;  // Divisor minus one
  logic [3:0]          edge_reg,    edge_next;     // Edge within conversion
  logic [5:0]          conv_reg,    conv_next;     // Conversion within set
  logic [2:0]          shift_reg,   shift_next;    // log2 of averages
  logic [ACC_W-1:0]    acc_reg,     acc_next;      // Running sum
  logic [RES_W-1:0]    samp_reg,    samp_next;     // Sampled input
  logic [RES_W-1:0]    res_reg,     res_next;      // Final result
  logic                tick;                       // Conversion-clock edge
  logic [ACC_W-1:0]    acc_sum;                    // Sum including this one

  assign busy   = busy_reg;
  assign done   = done_reg;
  assign result = res_reg;

  // Settings are captured at start so a mid-set rewrite cannot skew it
  always_comb begin
    busy_next    = busy_reg;
    done_next    = 1'b0;
    div_cnt_next = div_cnt_reg;
    div_max_next = div_max_reg;
    edge_next    = edge_reg;
    conv_next    = conv_reg;
    shift_next   = shift_reg;
    acc_next     = acc_reg;
    samp_next    = samp_reg;
    res_next     = res_reg;
    tick         = (div_cnt_reg == div_max_reg);
    acc_sum      = ACC_W'(acc_reg + {5'h00, samp_reg});
    if (!busy_reg) begin
      if (start) begin
        busy_next    = 1'b1;
        div_cnt_next = '0;
        edge_next    = '0;
        conv_next    = '0;
        acc_next     = '0;
        shift_next   = aas_avg_shift(avg_code);
        div_max_next = DIVC_W'((8'h01 << div_code) - 8'h01);
      end
    end else begin
      div_cnt_next = tick ? '0 : DIVC_W'(div_cnt_reg + 1'b1);
      if (tick) begin
        if (edge_reg == 4'(SAMPLE_EDGE)) begin
          samp_next = code_in;
        end
        if (edge_reg == 4'(CONV_EDGES - 1)) begin
          edge_next = '0;
          if (conv_reg == 6'((6'h01 << shift_reg) - 6'h01)) begin
            busy_next = 1'b0;
            done_next = 1'b1;
            res_next  = RES_W'(acc_sum >> shift_reg);
          end else begin
            conv_next = 6'(conv_reg + 1'b1);
            acc_next  = acc_sum;
          end
        end else begin
          edge_next = 4'(edge_reg + 1'b1);
        end
      end
    end
  end

  // State registers; nothing moves while the clock stands still
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      busy_reg    <= 1'b0;
      done_reg    <= 1'b0;
      div_cnt_reg <= '0;
      div_max_reg <= '0;
      edge_reg    <= '0;
      conv_reg    <= '0;
      shift_reg   <= '0;
      acc_reg     <= '0;
      samp_reg    <= '0;
      res_reg     <= '0;
    end else begin
      busy_reg    <= busy_next;
      done_reg    <= done_next;
      div_cnt_reg <= div_cnt_next;
      div_max_reg <= div_max_next;
      edge_reg    <= edge_next;
      conv_reg    <= conv_next;
      shift_reg   <= shift_next;
      acc_reg     <= acc_next;
      samp_reg    <= samp_next;
      res_reg     <= res_next;
    end
  end
endmodule : aas_conv_seq

//--- aas_aux_adc_serial_control.sv
`timescale 1ns/100ps
// Serial port, aux DAC retention and aux converter control
module aas_aux_adc_serial_control (
  input  wire logic                     clock,                 // System clock
  input  wire logic                     rst_n,                 // Synchronous reset
  input  wire logic                     link_clock,            // Serial clock
  input  wire logic                     cs_n,                  // Chip-select/wake
  input  wire logic                     din,                   // Serial data in
  input  wire logic [aas_pkg::RES_W-1:0] conv_code,            // Converter core code
  output logic                          dout,                  // Serial data out
  output logic                          dout_oe,               // Drive enable of dout
  output logic [1:0]                    aux_input_select,      // Input mux select
  output logic                          aux_reference_select,  // Reference select
  output logic [aas_pkg::DAC_W-1:0]     frequency_control_dac, // DAC code driven
  output logic [aas_pkg::DAC_W-1:0]     gain_control_dac_a,    // DAC code driven
  output logic [aas_pkg::DAC_W-1:0]     gain_control_dac_b,    // DAC code driven
  output logic                          dac_enable,            // DACs powered
  output logic [1:0]                    power_mode             // Current power mode
);
  import aas_pkg::*;

  // ---------------- Link domain (serial clock) ----------------
  logic               lrst_meta_reg;               // Reset sync stage 1
  logic               lrst_sync_reg;               // Reset sync stage 2
  logic [WORD_W-1:0]  shift_in_reg, shift_in_next; // Input shifter
  logic [3:0]         bit_cnt_reg,  bit_cnt_next;  // Bits of current frame
  logic [DAC_W-1:0]   code_f_reg,   code_f_next;   // Held frequency code
  logic [DAC_W-1:0]   code_a_reg,   code_a_next;   // Held gain code A
  logic [DAC_W-1:0]   code_b_reg,   code_b_next;   // Held gain code B
  logic [DAC_W-1:0]   out_f_reg,    out_f_next;    // Driven frequency code
  logic [DAC_W-1:0]   out_a_reg,    out_a_next;    // Driven gain code A
  logic [DAC_W-1:0]   out_b_reg,    out_b_next;    // Driven gain code B
  aas_pmode_e         pmode_reg,    pmode_next;    // Power mode
  logic [3:0]         out_idx_reg,  out_idx_next;  // Read bit index
  aas_word_s          frame;                       // Frame completing now
  logic               shut;                        // Shutdown after frame

  // Frame assembly and DAC updates; the serial clock alone drives these
  always_comb begin
    shift_in_next = shift_in_reg;
    bit_cnt_next  = bit_cnt_reg;
    code_f_next   = code_f_reg;
    code_a_next   = code_a_reg;
    code_b_next   = code_b_reg;
    pmode_next    = pmode_reg;
    frame         = {shift_in_reg[WORD_W-2:0], din};
    if (!cs_n) begin
      shift_in_next = frame;
      bit_cnt_next  = 4'(bit_cnt_reg + 1'b1);
      if (bit_cnt_reg == 4'(WORD_W - 1)) begin
        // Unlisted addresses, all-ones included, change nothing
        if (frame.addr == ADDR_DAC_FREQ) begin
          code_f_next = frame.data;
        end else if (frame.addr == ADDR_DAC_GA) begin
          code_a_next = frame.data;
        end else if (frame.addr == ADDR_DAC_GB) begin
          code_b_next = frame.data;
        end else if (frame.addr == ADDR_POWER) begin
          pmode_next = aas_pmode_e'(frame.data[1:0]);
        end
      end
    end
    shut       = (pmode_next == PM_SHUTDOWN);
    out_f_next = shut ? DAC_OFF : code_f_next;
    out_a_next = shut ? DAC_OFF : code_a_next;
    out_b_next = shut ? DAC_OFF : code_b_next;
  end

  // Link registers; reset needs serial clock edges while rst_n is low
  always_ff @(posedge link_clock) begin
    lrst_meta_reg <= rst_n;
    lrst_sync_reg <= lrst_meta_reg;
    if (!lrst_sync_reg) begin
      shift_in_reg <= '0;
      bit_cnt_reg  <= '0;
      code_f_reg   <= DAC_FREQ_RESET;
      code_a_reg   <= DAC_GAIN_RESET;
      code_b_reg   <= DAC_GAIN_RESET;
      out_f_reg    <= DAC_FREQ_RESET;
      out_a_reg    <= DAC_GAIN_RESET;
      out_b_reg    <= DAC_GAIN_RESET;
      pmode_reg    <= PM_NORMAL;
    end else begin
      shift_in_reg <= shift_in_next;
      bit_cnt_reg  <= bit_cnt_next;
      code_f_reg   <= code_f_next;
      code_a_reg   <= code_a_next;
      code_b_reg   <= code_b_next;
      out_f_reg    <= out_f_next;
      out_a_reg    <= out_a_next;
      out_b_reg    <= out_b_next;
      pmode_reg    <= pmode_next;
    end
  end

  assign frequency_control_dac = out_f_reg;
  assign gain_control_dac_a    = out_a_reg;
  assign gain_control_dac_b    = out_b_reg;
  assign power_mode            = pmode_reg;
  assign dac_enable            = (pmode_reg != PM_SHUTDOWN);

  // Read index advances on falling edges so data changes there
  always_comb begin
    out_idx_next = cs_n ? out_idx_reg : 4'(out_idx_reg + 1'b1);
  end

  // Falling-edge register; wraps after sixteen clocks
  always_ff @(negedge link_clock) begin
    if (!lrst_sync_reg) begin
      out_idx_reg <= '0;
    end else begin
      out_idx_reg <= out_idx_next;
    end
  end

  // ---------------- System clock domain ----------------
  logic               cs_meta_reg;                  // Chip-select sync 1
  logic               cs_sync_reg;                  // Chip-select sync 2
  logic               cs_prev_reg;                  // For rise detect
  logic [RES_W-1:0]   code_meta_reg;                // Code sync 1
  logic [RES_W-1:0]   code_sync_reg;                // Code sync 2
  aas_ctrl_s          ctrl_reg,    ctrl_next;       // Converter control
  aas_state_e         state_reg,   state_next;      // Converter state
  logic               stat_reg,    stat_next;       // Busy/ready drive on
  logic               block_reg,   block_next;      // Output disabled
  logic               rdwin_reg,   rdwin_next;      // Result shift allowed
  logic               cs_rise;                      // Frame latched
  logic               start_go;                     // Start the sequencer
  logic               seq_busy;                     // Sequencer running
  logic               seq_done;                     // Sequencer finished
  logic [RES_W-1:0]   seq_result;                   // Averaged result
  aas_word_s          word;                         // Latched frame
  aas_ctrl_s          wr;                           // Written control value
  logic               consumed;                     // Result read this frame
  logic [3:0]         rd_pos;                       // Result bit presented

  // Sequencer sees only the control value captured at start
  aas_conv_seq u_seq (
    .clock    (clock),
    .rst_n    (rst_n),
    .start    (start_go),
    .avg_code (ctrl_next.aux_average_count),
    .div_code (ctrl_next.aux_clock_divider),
    .code_in  (code_sync_reg),
    .busy     (seq_busy),
    .done     (seq_done),
    .result   (seq_result)
  );

  // Command handling; the frame shifter is still once chip-select is high
  always_comb begin
    ctrl_next  = ctrl_reg;
    state_next = state_reg;
    stat_next  = stat_reg;
    block_next = block_reg;
    start_go   = 1'b0;
    cs_rise    = cs_sync_reg && !cs_prev_reg;
    word       = shift_in_reg;
    wr         = aas_ctrl_s'(word.data[CTRL_W-1:0]);
    consumed   = cs_rise && rdwin_reg;
    if (seq_done) begin
      state_next                  = ST_READY;
      ctrl_next.aux_start_convert = 1'b0;
    end
    if (consumed) begin
      state_next = ST_IDLE;
      stat_next  = 1'b0;
    end
    if (cs_rise && word.addr == ADDR_AUX_CTRL) begin
      if (state_reg == ST_BUSY && !seq_done) begin
        ctrl_next                   = wr;
        ctrl_next.aux_start_convert = 1'b1;
      end else if (state_reg == ST_READY && !consumed) begin
        ctrl_next                   = wr;
        ctrl_next.aux_start_convert = 1'b0;
        if (wr.aux_start_convert && !ctrl_reg.aux_result_output_enable) begin
          block_next = 1'b1;
          stat_next  = 1'b0;
        end
      end else begin
        ctrl_next = wr;
        if (wr.aux_start_convert && !block_reg) begin
          state_next = ST_BUSY;
          stat_next  = 1'b1;
          start_go   = 1'b1;
        end else begin
          ctrl_next.aux_start_convert = 1'b0;
        end
      end
      if (!wr.aux_start_convert) begin
        block_next = 1'b0;
      end
    end
    // Shift only with output enabled and nothing disabling the pin
    rdwin_next = (state_next == ST_READY) && !block_next &&
                 ctrl_next.aux_result_output_enable;
  end

  // Registers hold every value for as long as the clock is stopped
  always_ff @(posedge clock) begin
    cs_meta_reg   <= cs_n;
    cs_sync_reg   <= cs_meta_reg;
    code_meta_reg <= conv_code;
    code_sync_reg <= code_meta_reg;
    if (!rst_n) begin
      cs_prev_reg <= 1'b1;
      ctrl_reg    <= aas_ctrl_s'(CTRL_RESET);
      state_reg   <= ST_IDLE;
      stat_reg    <= 1'b0;
      block_reg   <= 1'b0;
      rdwin_reg   <= 1'b0;
    end else begin
      cs_prev_reg <= cs_sync_reg;
      ctrl_reg    <= ctrl_next;
      state_reg   <= state_next;
      stat_reg    <= stat_next;
      block_reg   <= block_next;
      rdwin_reg   <= rdwin_next;
    end
  end

  assign aux_input_select     = ctrl_reg.aux_input_select;
  assign aux_reference_select = ctrl_reg.aux_reference_select;

  // Pin driver: result while selected and enabled, else busy/ready level.
  // The select is the raw chip-select so the first bit is on time; a
  // result read whose low period began before ready may be partial.
  always_comb begin
    rd_pos = (out_idx_reg > RES_LAST_IDX) ? RES_LAST_IDX : out_idx_reg;
    if (!cs_n && rdwin_reg) begin
      dout    = seq_result[RES_LAST_IDX - rd_pos];
      dout_oe = 1'b1;
    end else begin
      dout    = (state_reg == ST_BUSY);
      dout_oe = stat_reg;
    end
  end
endmodule : aas_aux_adc_serial_control

//--- aas_aux_adc_serial_control_properties.sv
`timescale 1ns/100ps
// Port-level checks of the aux converter control block
module aas_aux_adc_serial_control_properties
  import aas_pkg::*;
(
  input wire logic             clock,                 // System clock
  input wire logic             rst_n,                 // Synchronous reset
  input wire logic             cs_n,                  // Chip-select/wake
  input wire logic             dout,                  // Serial data out
  input wire logic             dout_oe,               // Drive enable of dout
  input wire logic [1:0]       aux_input_select,      // Input mux select
  input wire logic             aux_reference_select,  // Reference select
  input wire logic [DAC_W-1:0] frequency_control_dac, // DAC code
  input wire logic [DAC_W-1:0] gain_control_dac_a,    // DAC code
  input wire logic [DAC_W-1:0] gain_control_dac_b,    // DAC code
  input wire logic             dac_enable,            // DACs powered
  input wire logic [1:0]       power_mode             // Current mode
);
  logic [7:0] busy_cnt_reg;   // Consecutive busy cycles seen
  logic [7:0] busy_cnt_next;  // Next count

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Count busy cycles; saturates so long conversions never wrap to a small value
  always_comb begin
    busy_cnt_next = busy_cnt_reg;
    if (!(dout_oe && dout && cs_n)) busy_cnt_next = 8'h00;
    else if (busy_cnt_reg != 8'hff) busy_cnt_next = busy_cnt_reg + 8'h01;
  end

  // Register only
  always_ff @(posedge clock) begin
    busy_cnt_reg <= rst_n ? busy_cnt_next : 8'h00;
  end

  a_reset_defaults: assert property ($rose(rst_n) |-> !dout_oe && power_mode == 2'h0 &&
    frequency_control_dac == DAC_FREQ_RESET && gain_control_dac_a == DAC_GAIN_RESET &&
    gain_control_dac_b == DAC_GAIN_RESET) else $error("reset values wrong");
  a_busy_on_start: assert property ($rose(dout_oe) && cs_n |-> dout)
    else $error("start did not show busy");
  a_busy_min_time: assert property ($fell(dout) && dout_oe && cs_n && $past(cs_n) |->
    busy_cnt_reg >= 8'h0c) else $error("conversion shorter than twelve edges");
  a_ready_no_restart: assert property (dout_oe && !dout && cs_n && $past(cs_n, 3) |=>
    !(dout_oe && dout && cs_n)) else $error("restart while result unread");
  a_mux_latch_time: assert property ($changed(aux_input_select) |-> cs_n && $past(cs_n, 2))
    else $error("input select changed inside a frame");
  a_ref_latch_time: assert property ($changed(aux_reference_select) |-> cs_n &&
    $past(cs_n, 2)) else $error("reference changed inside a frame");
  a_mode_in_frame: assert property ($changed(power_mode) |-> !cs_n)
    else $error("power mode changed outside a frame");
  a_shutdown_dacs_off: assert property (power_mode == 2'h3 |-> !dac_enable &&
    frequency_control_dac == DAC_OFF && gain_control_dac_a == DAC_OFF &&
    gain_control_dac_b == DAC_OFF) else $error("DACs live in shutdown");
  a_active_dacs_on: assert property (power_mode != 2'h3 |-> dac_enable)
    else $error("DACs off outside shutdown");

  c_busy_seen: cover property ($rose(dout_oe) && cs_n);
  c_ready_seen: cover property ($fell(dout) && dout_oe && cs_n);
  c_shutdown_seen: cover property (power_mode == 2'h3);
endmodule : aas_aux_adc_serial_control_properties

bind aas_aux_adc_serial_control aas_aux_adc_serial_control_properties u_props (
  .clock(clock), .rst_n(rst_n), .cs_n(cs_n), .dout(dout), .dout_oe(dout_oe),
  .aux_input_select(aux_input_select), .aux_reference_select(aux_reference_select),
  .frequency_control_dac(frequency_control_dac), .gain_control_dac_a(gain_control_dac_a),
  .gain_control_dac_b(gain_control_dac_b), .dac_enable(dac_enable), .power_mode(power_mode));

//--- aas_host_model.sv
`timescale 1ns/100ps
// Host on the three-wire port: sends frames, captures dout on rising edges
module aas_host_model (
  input  wire logic   rst_n,       // Reset, link clock runs while low
  input  wire logic   dout,        // Serial data out
  input  wire logic   dout_oe,     // Drive enable of dout
  output logic        link_clock,  // Serial clock
  output logic        cs_n,        // Chip-select/wake
  output logic        din,         // Serial data in
  output logic [15:0] rd_word      // Last captured read word
);
  event rd_ev;  // Fires when a captured word is ready

  initial begin
    link_clock = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
    rd_word = 16'h0000;
  end

  int post;  // Rising link edges since reset release

  // Clock runs in reset and for three edges after it so the link reset
  // synchroniser releases before the first frame, then parks low
  always #16 if (!rst_n || post < 3 || (cs_n && link_clock)) link_clock = ~link_clock;
  always @(posedge link_clock) post = rst_n ? post + 1 : 0;

  // One sixteen-bit frame, gap first so cs high lasts past 80 ns
  task automatic frame(input logic [15:0] w, input logic listen);
    logic [15:0] cap;
    cap = 16'h0000;
    #96;
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      din = w[i];
      #16 link_clock = 1'b1;
      cap[i] = dout_oe ? dout : 1'bz;
      #16 link_clock = 1'b0;
    end
    #16 cs_n = 1'b1;
    din = ~din;                 // Released line shows no stale value
    if (listen) begin
      rd_word = cap;
      ->rd_ev;
    end
  endtask : frame
endmodule : aas_host_model

//--- aas_aux_adc_serial_control_bench.sv
`timescale 1ns/100ps
// Bench: host model on the serial port, converter code driven here
module aas_aux_adc_serial_control_bench;
  import aas_pkg::*;
  logic             clock, rst_n, clock_run;     // System clock, reset, clock gate
  logic             link_clock, cs_n, din;       // Serial port
  logic             dout, dout_oe, dac_enable;   // Device outputs
  logic             aux_reference_select;        // Reference select
  logic [1:0]       aux_input_select, power_mode; // Mux select, mode
  logic [RES_W-1:0] conv_code, code;             // Converter code
  logic [DAC_W-1:0] frequency_control_dac, gain_control_dac_a, gain_control_dac_b;
  logic [DAC_W-1:0] dac_q [1:3];                 // Last written DAC codes
  logic [15:0]      rd_word;                     // Word read by host
  logic [15:0]      exp_q [$];                   // Expected read words
  aas_ctrl_s        c;                           // Control word
  int               errors, comparisons, ticks, n, t, dv;

  // Gated so the system clock can be held static
  always #5 if (clock_run) clock = ~clock;

  aas_aux_adc_serial_control u_dut (.clock(clock), .rst_n(rst_n), .link_clock(link_clock),
    .cs_n(cs_n), .din(din), .conv_code(conv_code), .dout(dout), .dout_oe(dout_oe),
    .aux_input_select(aux_input_select), .aux_reference_select(aux_reference_select),
    .frequency_control_dac(frequency_control_dac), .gain_control_dac_a(gain_control_dac_a),
    .gain_control_dac_b(gain_control_dac_b), .dac_enable(dac_enable), .power_mode(power_mode));
  aas_host_model u_host (.rst_n(rst_n), .dout(dout), .dout_oe(dout_oe),
    .link_clock(link_clock), .cs_n(cs_n), .din(din), .rd_word(rd_word));

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  function automatic logic [DAC_W-1:0] dac_at(input int a);
    return (a == 1) ? frequency_control_dac : (a == 2) ? gain_control_dac_a : gain_control_dac_b;
  endfunction : dac_at

  // Bounded wait for busy, then for the ready level driven low after it
  task automatic wait_ready(input int lim);
    logic seen;
    seen = 1'b0;
    n = 0;
    while (!(seen && dout_oe === 1'b1 && dout === 1'b0) && n < lim) begin
      @(negedge clock);
      seen = seen || (dout_oe === 1'b1 && dout === 1'b1);
      n++;
    end
  endtask : wait_ready

  // Monitor: each captured read is matched against the oldest note
  always @(u_host.rd_ev) begin
    if (exp_q.size() == 0) check("unexpected read", 16'h0000, 16'hffff);
    else check("read word", exp_q.pop_front(), rd_word);
  end

  // Cut a hang short; the longest averaged set is about 12k cycles
  always @(posedge clock) begin
    ticks++;
    if (ticks > 80000) begin
      errors++;
      report_and_stop();
    end
  end

  initial begin
    errors = 0;
    comparisons = 0;
    ticks = 0;
    clock = 1'b0;
    clock_run = 1'b1;
    rst_n = 1'b0;
    conv_code = 10'h000;
    void'($urandom(27));
    repeat (12) @(posedge clock);
    @(negedge clock) rst_n = 1'b1;
    repeat (8) @(negedge clock);
    // DAC writes; the middle one goes in with the system clock stopped
    for (int a = 1; a <= 3; a++) begin
      dac_q[a] = 12'($urandom);
      clock_run = (a != 2);
      u_host.frame({4'(a), dac_q[a]}, 1'b0);
      check("dac code", 16'(dac_q[a]), 16'(dac_at(a)));
      clock_run = 1'b1;  // Conversions start about 7.1 us later
    end
    u_host.frame(16'hffff, 1'b0);
    // Shutdown, standby, idle, normal: codes off then restored
    for (int m = 3; m >= 0; m--) begin
      u_host.frame({ADDR_POWER, 12'(m)}, 1'b0);
      for (int a = 1; a <= 3; a++)
        check("dac in mode", 16'(m == 3 ? DAC_OFF : dac_q[a]), 16'(dac_at(a)));
      check("power mode", 16'(m), 16'(power_mode));
    end
    // Every input route and both references
    for (int s = 0; s < 4; s++) begin
      c = '{1'b0, 3'h0, 3'h0, 2'(s), s[0], 1'b0};
      u_host.frame({ADDR_AUX_CTRL, 1'b0, c}, 1'b0);
      repeat (5) @(negedge clock);
      check("input select", 16'(s), 16'(aux_input_select));
      check("reference", 16'(s[0]), 16'(aux_reference_select));
    end
    // Back-to-back: each frame after the first reads the last result; all but the last start the next
    for (int i = 0; i <= 8; i++) begin
      if (i > 0) exp_q.push_back({code, {6{code[0]}}});
      code = 10'($urandom);
      @(negedge clock) conv_code = code;
      dv = (i < 3) ? 7 - i : 5;  // Divisors of 32 and up keep 4 MHz at most
      c = '{1'b1, 3'(dv), 3'(i), 2'(i), 1'b0, 1'b1};
      u_host.frame((i < 8) ? {ADDR_AUX_CTRL, 1'b0, c} : 16'hffff, i > 0);
      if (i < 8) begin
        t = 12 * (1 << (i > 5 ? 5 : i)) * (1 << dv);
        wait_ready(t + 40);
        check("conversion time", 16'h0001, 16'(n >= t && n <= t + 8));
      end
    end
    // Start with output off, then a second start: output must be disabled
    code = 10'($urandom);
    @(negedge clock) conv_code = code;
    c = '{1'b0, 3'h5, 3'h0, 2'h0, 1'b0, 1'b1};
    u_host.frame({ADDR_AUX_CTRL, 1'b0, c}, 1'b0);
    wait_ready(500);
    check("ready level", 16'h0001, 16'(n < 500));
    c.aux_result_output_enable = 1'b1;
    u_host.frame({ADDR_AUX_CTRL, 1'b0, c}, 1'b0);
    repeat (6) @(negedge clock);
    check("output disabled", 16'h0000, 16'(dout_oe));
    // Second reset in mid-run
    rst_n = 1'b0;
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    check("reset state", 16'h0000,
      16'({dout_oe, aux_input_select, aux_reference_select, power_mode}));
    check("dac reset", 16'(DAC_FREQ_RESET), 16'(frequency_control_dac));
    report_and_stop();
  end
endmodule : aas_aux_adc_serial_control_bench
